// ---- verilog/ssg_pkg.sv ----
// Package of offsets, field positions and types for the status/pin bank.
package ssg_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] OFS_SCRATCH   = 12'h40c;
  localparam logic [11:0] OFS_PIN_FUNC  = 12'h418;
  localparam logic [11:0] OFS_PIN_DIR   = 12'h41c;
  localparam logic [11:0] OFS_PIN_DATA  = 12'h420;
  localparam logic [11:0] OFS_BUS_STS   = 12'h424;
  localparam logic [11:0] OFS_LOAD_CTL  = 12'h440;
  localparam logic [11:0] OFS_IRQ_STS   = 12'h444;
  localparam logic [11:0] OFS_IRQ_EN    = 12'h448;
  localparam logic [11:0] OFS_IRQ_CLR   = 12'h44c;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int SLV_ADDR_LSB  = 1;
  localparam int MST_ADDR_LSB  = 9;
  localparam int LOAD_DONE_BIT = 24;
  localparam int NACK_BIT      = 25;
  localparam int ARB_BIT       = 26;
  localparam int COND_BIT      = 27;
  localparam int CSUM_BIT      = 28;
  localparam int UNMAP_BIT     = 29;
  localparam int IGN_CSUM_BIT  = 17;
  localparam logic [31:0] SCRATCH_RST = 32'h0000_0000;
  localparam logic [15:0] PIN_RST     = 16'h0000;
  localparam logic [4:0]  ARB_LIMIT   = 5'h10;
  localparam int NUM_EVT = 6;

  // Event index in the interrupt status register.
  typedef enum logic [2:0] {
    EVT_LOAD_DONE = 3'h0,
    EVT_NACK      = 3'h1,
    EVT_ARB       = 3'h2,
    EVT_COND      = 3'h3,
    EVT_CSUM      = 3'h4,
    EVT_UNMAP     = 3'h5
  } ssg_evt_type;

  // Register port request.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ssg_req_type;

  // Event reports from the bus master engine and the loader.
  typedef struct packed {
    logic load_done;
    logic load_csum_bad;
    logic load_no_done_cmd;
    logic load_unmapped;
    logic nack;
    logic arb_lost;
    logic arb_won;
    logic cond_misplaced;
  } ssg_evt_in_type;

endpackage : ssg_pkg

// ---- verilog/ssg_regs.sv ----
// Status, scratch and general purpose pin register bank.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Summary of operation
// RL1: Scratch word is 32-bit read/write, no hardware effect, resets to zero.
// RL2: Function bit set routes a pin to alternate function, clear means GPIO.
// RL3: In GPIO mode a set direction bit drives the pin as output.
// RL4: In alternate mode the alternate function governs direction and level.
// RL5: Reading pin data returns the present level of all sixteen pins.
// RL6: Writing pin data changes only pins configured as GPIO outputs.
// RL7: Status reports slave address in bits 7:1, master in 15:9.
// RL8: Load done bit 24 sets when EEPROM loading finishes or errors.
// RL9: Flag bit 25 sets on an unexpected not-acknowledge, write one clears.
// RL10: Sixteen consecutive arbitration losses abort and set flag bit 26.
// RL11: Flag bit 27 sets on a misplaced START or STOP condition.
// RL12: Flag bit 28 sets on bad checksum or missing done command.
// RL13: Flag bit 29 sets when loading targets an undefined register.
// RL14: Ignore-checksum bit makes every checksum pass, no flag raised.
// RL15: Reserved bits read as zero and ignore writes.
module ssg_regs
  import ssg_pkg::*;
#(
  parameter int PINS = 16
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // Register port
  input  wire ssg_req_type       req,
  output logic [31:0]            rdata,
  // Hardware initialised addresses, steady after reset
  input  wire logic [6:0]        slave_bus_address,
  input  wire logic [6:0]        master_bus_address,
  // Engine and loader events
  input  wire ssg_evt_in_type    evt,
  output logic                   arb_abort,
  // Pins
  input  wire logic [PINS-1:0]   pin_in,
  output logic [PINS-1:0]        pin_out,
  output logic [PINS-1:0]        pin_oe_n,
  // Alternate function side
  input  wire logic [PINS-1:0]   alt_out,
  input  wire logic [PINS-1:0]   alt_drive,
  // Interrupt
  output logic                   irq
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [31:0]        scratch_q;
  logic [PINS-1:0]    func_q, dir_q, gpo_q;
  logic [PINS-1:0]    pin_out_q, pin_oe_n_q;
  logic [6:0]         slv_q, mst_q;
  logic               done_q, ign_csum_q, abort_q, irq_q;
  logic [4:0]         arb_cnt_q, arb_cnt_d;
  logic [4:0]         flag_q, flag_d;
  logic [NUM_EVT-1:0] ists_q, ists_d, ien_q, evt_set;
  logic [31:0]        rdata_q, rdata_d;

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic logic hit(input ssg_req_type r, input logic [11:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  wire w_scr  = hit(req, OFS_SCRATCH);
  wire w_func = hit(req, OFS_PIN_FUNC);
  wire w_dir  = hit(req, OFS_PIN_DIR);
  wire w_data = hit(req, OFS_PIN_DATA);
  wire w_sts  = hit(req, OFS_BUS_STS);
  wire w_ctl  = hit(req, OFS_LOAD_CTL);
  wire w_ien  = hit(req, OFS_IRQ_EN);
  wire w_iclr = hit(req, OFS_IRQ_CLR);

  // Checksum failure is masked by the ignore control.
  wire csum_err = (evt.load_csum_bad && !ign_csum_q)
                  || evt.load_no_done_cmd;            // see RL12 see RL14
  wire arb_lim  = evt.arb_lost && (arb_cnt_q == ARB_LIMIT - 5'h01);
  wire [4:0] flag_set = {evt.load_unmapped, csum_err,
                         evt.cond_misplaced, arb_lim, evt.nack};
  wire [4:0] flag_clr = w_sts ? req.wdata[UNMAP_BIT:NACK_BIT] : 5'h00;

  // Set wins over a same-cycle clear.
  assign flag_d = (flag_q & ~flag_clr) | flag_set;    // see RL9 see RL11

  // Losses count only while consecutive; any win restarts the count.
  assign arb_cnt_d = (evt.arb_won || arb_lim) ? 5'h00 :
                     evt.arb_lost ? arb_cnt_q + 5'h01 : arb_cnt_q;

  assign evt_set = {evt.load_unmapped, csum_err, evt.cond_misplaced,
                    arb_lim, evt.nack, evt.load_done && !done_q};
  assign ists_d  = (ists_q & ~(w_iclr ? req.wdata[NUM_EVT-1:0]
                                      : {NUM_EVT{1'b0}})) | evt_set;

  wire [PINS-1:0] gpo_d = w_data ? ((gpo_q & ~(dir_q & ~func_q))
                   | (req.wdata[PINS-1:0] & dir_q & ~func_q))
                   : gpo_q;                           // see RL6

  wire [31:0] sts_word = {2'h0, flag_q, done_q, 8'h00, mst_q, 1'b0,
                          slv_q, 1'b0};               // see RL7 see RL15

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (req.rd) begin
      case (req.addr)
        OFS_SCRATCH:  rdata_d = scratch_q;            // see RL1
        OFS_PIN_FUNC: rdata_d = {16'h0000, func_q};
        OFS_PIN_DIR:  rdata_d = {16'h0000, dir_q};
        OFS_PIN_DATA: rdata_d = {16'h0000, pin_in};   // see RL5
        OFS_BUS_STS:  rdata_d = sts_word;
        OFS_LOAD_CTL: rdata_d = 32'(ign_csum_q) << IGN_CSUM_BIT;
        OFS_IRQ_STS:  rdata_d = {26'h0, ists_q};
        OFS_IRQ_EN:   rdata_d = {26'h0, ien_q};
        default:      rdata_d = 32'h0000_0000;        // see RL15
      endcase
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          pin_out_q[g]  <= 1'b0;
          pin_oe_n_q[g] <= 1'b1;
        end else if (func_q[g]) begin                 // see RL2 see RL4
          pin_out_q[g]  <= alt_out[g];
          pin_oe_n_q[g] <= ~alt_drive[g];
        end else begin                                // see RL3
          pin_out_q[g]  <= gpo_d[g];
          pin_oe_n_q[g] <= ~dir_q[g];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      scratch_q  <= SCRATCH_RST;
      func_q     <= PIN_RST;
      dir_q      <= PIN_RST;
      gpo_q      <= PIN_RST;
      ign_csum_q <= 1'b0;
      ien_q      <= '0;
    end else begin
      if (w_scr)  scratch_q  <= req.wdata;           // see RL1
      if (w_func) func_q     <= req.wdata[PINS-1:0];
      if (w_dir)  dir_q      <= req.wdata[PINS-1:0];
      if (w_ctl)  ign_csum_q <= req.wdata[IGN_CSUM_BIT];
      if (w_ien)  ien_q      <= req.wdata[NUM_EVT-1:0];
      gpo_q <= gpo_d;
    end
  end

  // Addresses are strapped, so they are caught one edge after release.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slv_q     <= 7'h00;
      mst_q     <= 7'h00;
      done_q    <= 1'b0;
      flag_q    <= 5'h00;
      arb_cnt_q <= 5'h00;
      abort_q   <= 1'b0;
      ists_q    <= '0;
      irq_q     <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end else begin
      slv_q     <= slave_bus_address;
      mst_q     <= master_bus_address;
      done_q    <= done_q | evt.load_done | csum_err
                   | evt.load_unmapped;               // see RL8
      flag_q    <= flag_d;                            // see RL13
      arb_cnt_q <= arb_cnt_d;
      abort_q   <= arb_lim;                           // see RL10
      ists_q    <= ists_d;
      irq_q     <= |(ists_d & ien_q);
      rdata_q   <= rdata_d;
    end
  end

  assign rdata     = rdata_q;
  assign pin_out   = pin_out_q;
  assign pin_oe_n  = pin_oe_n_q;
  assign arb_abort = abort_q;
  assign irq       = irq_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Sequences name the steps of the properties; only s_sts_read is shared, by two.
  sequence s_sts_clear;
    w_sts && req.wdata[NACK_BIT] && !evt.nack;
  endsequence

  sequence s_scr_read;
    req.rd && (req.addr == OFS_SCRATCH);
  endsequence

  sequence s_sts_read;
    req.rd && (req.addr == OFS_BUS_STS);
  endsequence

  sequence s_pin_read;
    req.rd && ((req.addr == OFS_PIN_FUNC) || (req.addr == OFS_PIN_DIR)
               || (req.addr == OFS_PIN_DATA));
  endsequence

  sequence s_gpo_write;
    w_data && !func_q[0] && dir_q[0];
  endsequence

  sequence s_arb_last;
    evt.arb_lost && (arb_cnt_q == 5'h0f);
  endsequence

  sequence s_ists_clear;
    w_iclr && req.wdata[1] && !evt.nack;
  endsequence

  AST_SCRATCH_RW: assert property ( // see RL1
    @(posedge sys_clk) disable iff (!resetn)
    w_scr |=> scratch_q == $past(req.wdata))
    else $error("scratch write lost");

  AST_SCRATCH_RD: assert property ( // see RL1
    @(posedge sys_clk) disable iff (!resetn)
    s_scr_read |=> rdata == $past(scratch_q))
    else $error("scratch readback differs");

  AST_SCRATCH_HOLD: assert property ( // see RL1
    @(posedge sys_clk) disable iff (!resetn)
    !w_scr |=> $stable(scratch_q))
    else $error("scratch changed without write");

  AST_FUNC_WR: assert property ( // see RL2
    @(posedge sys_clk) disable iff (!resetn)
    w_func |=> func_q == $past(req.wdata[PINS-1:0]))
    else $error("function write lost");

  AST_ALT_NODIR: assert property ( // see RL2
    @(posedge sys_clk) disable iff (!resetn)
    func_q[4] |=> pin_oe_n[4] == !$past(alt_drive[4]))
    else $error("alternate pin follows direction bit");

  AST_DIR_WR: assert property ( // see RL3
    @(posedge sys_clk) disable iff (!resetn)
    w_dir |=> dir_q == $past(req.wdata[PINS-1:0]))
    else $error("direction write lost");

  AST_GPIO_OE: assert property ( // see RL3
    @(posedge sys_clk) disable iff (!resetn)
    !func_q[0] |=> pin_oe_n[0] == !$past(dir_q[0]))
    else $error("gpio enable wrong");

  AST_ALT_OE: assert property ( // see RL4
    @(posedge sys_clk) disable iff (!resetn)
    func_q[6] |=> pin_out[6] == $past(alt_out[6])
                  && pin_oe_n[6] == !$past(alt_drive[6]))
    else $error("alternate level wrong");

  AST_PIN_READ: assert property ( // see RL5
    @(posedge sys_clk) disable iff (!resetn)
    req.rd && req.addr == OFS_PIN_DATA
    |=> rdata == {16'h0000, $past(pin_in)})
    else $error("pin read wrong");

  AST_DATA_WRITE: assert property ( // see RL6
    @(posedge sys_clk) disable iff (!resetn)
    s_gpo_write |=> pin_out[0] == $past(req.wdata[0]))
    else $error("gpio write lost");

  AST_DATA_HOLD: assert property ( // see RL6
    @(posedge sys_clk) disable iff (!resetn)
    w_data && !dir_q[12] |=> gpo_q[12] == $past(gpo_q[12]))
    else $error("input pin latch changed");

  AST_STS_ADDR: assert property ( // see RL7
    @(posedge sys_clk) disable iff (!resetn)
    s_sts_read |=> rdata[15:9] == $past(mst_q)
                   && rdata[7:1] == $past(slv_q))
    else $error("bus address field wrong");

  AST_DONE: assert property ( // see RL8
    @(posedge sys_clk) disable iff (!resetn)
    evt.load_done |=> done_q && sts_word[LOAD_DONE_BIT])
    else $error("load done not shown");

  AST_DONE_STICKY: assert property ( // see RL8
    @(posedge sys_clk) disable iff (!resetn)
    done_q |=> done_q)
    else $error("load done dropped");

  AST_NACK_SET: assert property ( // see RL9
    @(posedge sys_clk) disable iff (!resetn)
    evt.nack |=> flag_q[0])
    else $error("nack flag not set");

  AST_NACK_CLR: assert property ( // see RL9
    @(posedge sys_clk) disable iff (!resetn)
    s_sts_clear |=> !flag_q[0])
    else $error("nack flag not cleared");

  AST_ARB_LIMIT: assert property ( // see RL10
    @(posedge sys_clk) disable iff (!resetn)
    s_arb_last |=> arb_abort && flag_q[1])
    else $error("arbitration abort missing");

  AST_ARB_EARLY: assert property ( // see RL10
    @(posedge sys_clk) disable iff (!resetn)
    evt.arb_lost && (arb_cnt_q < 5'h0f) |=> !arb_abort)
    else $error("arbitration abort too early");

  AST_ARB_WIN: assert property ( // see RL10
    @(posedge sys_clk) disable iff (!resetn)
    evt.arb_won |=> arb_cnt_q == 5'h00)
    else $error("loss count not restarted");

  AST_COND_SET: assert property ( // see RL11
    @(posedge sys_clk) disable iff (!resetn)
    evt.cond_misplaced |=> flag_q[2])
    else $error("condition flag not set");

  AST_CSUM_SET: assert property ( // see RL12
    @(posedge sys_clk) disable iff (!resetn)
    evt.load_no_done_cmd |=> flag_q[3])
    else $error("checksum flag not set");

  AST_UNMAP_SET: assert property ( // see RL13
    @(posedge sys_clk) disable iff (!resetn)
    evt.load_unmapped |=> flag_q[4])
    else $error("unmapped flag not set");

  AST_CSUM_IGN: assert property ( // see RL14
    @(posedge sys_clk) disable iff (!resetn)
    ign_csum_q && !flag_q[3] && !evt.load_no_done_cmd
    |=> !flag_q[3])
    else $error("checksum flag despite ignore");

  AST_STS_RSVD: assert property ( // see RL15
    @(posedge sys_clk) disable iff (!resetn)
    s_sts_read |=> rdata[31:30] == 2'h0 && rdata[23:16] == 8'h00
                   && !rdata[8] && !rdata[0])
    else $error("status reserved bits set");

  AST_PIN_RSVD: assert property ( // see RL15
    @(posedge sys_clk) disable iff (!resetn)
    s_pin_read |=> rdata[31:16] == 16'h0000)
    else $error("pin reserved bits set");

  AST_CTL_RSVD: assert property ( // see RL15
    @(posedge sys_clk) disable iff (!resetn)
    req.rd && (req.addr == OFS_LOAD_CTL)
    |=> rdata[16:0] == 17'h00000 && rdata[31:18] == 14'h0000)
    else $error("control reserved bits set");

  AST_RD_IDLE: assert property ( // see RL15
    @(posedge sys_clk) disable iff (!resetn)
    !req.rd |=> rdata == 32'h0000_0000)
    else $error("read data outside read");

  AST_IRQ: assert property ( // see RL9
    @(posedge sys_clk) disable iff (!resetn)
    $rose(ists_q[1]) && $past(ien_q[1]) |-> irq)
    else $error("interrupt missing");

  AST_IRQ_IDLE: assert property ( // see RL9
    @(posedge sys_clk) disable iff (!resetn)
    !(|ists_q) |-> !irq)
    else $error("interrupt without status");

  AST_IST_CLR: assert property ( // see RL9
    @(posedge sys_clk) disable iff (!resetn)
    s_ists_clear |=> !ists_q[1])
    else $error("interrupt status not cleared");

endmodule : ssg_regs

// ---- sim/ssg_pin_model.sv ----
// Pin-side model: outside logic that drives every pin the bank leaves.
`timescale 1ns/1ps
module ssg_pin_model (
  // Bank side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  // Outside side
  input  wire logic [15:0] ext_level,
  output logic [15:0]      pin_in
);
  // A pin shows the bank's level only while the bank drives it.
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule : ssg_pin_model

// ---- sim/tb.sv ----
// Self-checking bench for the status, scratch and pin register bank.
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))
module tb
  import ssg_pkg::*;
;
  logic           sys_clk = 1'b0;
  logic           resetn = 1'b0;
  ssg_req_type    req = '0;
  ssg_evt_in_type evt = '0;
  logic [31:0]    rdata;
  logic [15:0]    pin_in, pin_out, pin_oe_n;
  logic [15:0]    ext_level = 16'h1234;
  logic [15:0]    alt_out = 16'h0050;
  logic [15:0]    alt_drive = 16'h00c0;
  logic           arb_abort, irq;
  int             failures = 0;
  int             total_checks = 0;
  int             aborts = 0;
  logic [7:0]     ev [4] = '{8'h08, 8'h01, 8'h40, 8'h10};
  int             bt [4] = '{25, 27, 28, 29};
  logic [31:0]    sts = {16'h0, 7'h33, 1'b0, 7'h5a, 1'b0};

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (arb_abort === 1'b1) aborts <= aborts + 1;

  ssg_regs dut (.sys_clk(sys_clk), .resetn(resetn), .req(req),
    .rdata(rdata), .slave_bus_address(7'h5a), .master_bus_address(7'h33),
    .evt(evt), .arb_abort(arb_abort), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .alt_out(alt_out), .alt_drive(alt_drive),
    .irq(irq));
  ssg_pin_model pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_level(ext_level), .pin_in(pin_in));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 `CHK(rdata, e);
  endtask : rd_chk
  task automatic pulse(input logic [7:0] e);
    @(posedge sys_clk);
    evt <= e;
    @(posedge sys_clk);
    evt <= '0;
  endtask : pulse
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rd_chk(OFS_SCRATCH, SCRATCH_RST);
    rd_chk(OFS_PIN_FUNC, 32'h0);
    rd_chk(OFS_PIN_DIR, 32'h0);
    `CHK(pin_oe_n, 16'hffff);
    wr(OFS_SCRATCH, 32'hdead_beef);
    rd_chk(OFS_SCRATCH, 32'hdead_beef);
    wr(12'h404, 32'hffff_ffff);
    rd_chk(12'h404, 32'h0);
    $display("scratch test done");
    // Direction bits 4 and 5 are set but must lose to the alternate side.
    wr(OFS_PIN_FUNC, 32'hffff_00f0);
    wr(OFS_PIN_DIR, 32'hffff_0fff);
    rd_chk(OFS_PIN_FUNC, 32'h0000_00f0);
    rd_chk(OFS_PIN_DIR, 32'h0000_0fff);
    wr(OFS_PIN_DATA, 32'hffff_ffff);
    settle();
    `CHK(pin_oe_n, 16'hf030);
    `CHK(pin_out & ~pin_oe_n, 16'h0f4f);
    rd_chk(OFS_PIN_DATA, 32'h1f7f);
    wr(OFS_PIN_DATA, 32'h0);
    settle();
    `CHK(pin_out & ~pin_oe_n, 16'h0040);
    rd_chk(OFS_PIN_DATA, 32'h1070);
    $display("pin test done");
    rd_chk(OFS_BUS_STS, sts);
    pulse(8'h80);
    sts[LOAD_DONE_BIT] = 1'b1;
    wr(OFS_BUS_STS, 32'h0100_0000);
    rd_chk(OFS_BUS_STS, sts);
    for (int i = 0; i < 4; i++) begin
      pulse(ev[i]);
      rd_chk(OFS_BUS_STS, sts | (32'h1 << bt[i]));
      wr(OFS_BUS_STS, 32'h1 << bt[i]);
      rd_chk(OFS_BUS_STS, sts);
    end
    wr(OFS_LOAD_CTL, 32'h1 << IGN_CSUM_BIT);
    rd_chk(OFS_LOAD_CTL, 32'h0002_0000);
    pulse(8'h40);
    rd_chk(OFS_BUS_STS, sts);
    pulse(8'h20);
    rd_chk(OFS_BUS_STS, sts | 32'h1000_0000);
    wr(OFS_BUS_STS, 32'h1000_0000);
    $display("status test done");
    // A win between losses restarts the count of consecutive losses.
    repeat (15) pulse(8'h04);
    pulse(8'h02);
    repeat (15) pulse(8'h04);
    rd_chk(OFS_BUS_STS, sts);
    `CHK(aborts, 0);
    pulse(8'h04);
    rd_chk(OFS_BUS_STS, sts | 32'h0400_0000);
    `CHK(aborts, 1);
    $display("arbitration test done");
    rd_chk(OFS_IRQ_STS, 32'h3f);
    `CHK(irq, 0);
    wr(OFS_IRQ_EN, 32'h2);
    settle();
    `CHK(irq, 1);
    wr(OFS_IRQ_CLR, 32'h3f);
    settle();
    `CHK(irq, 0);
    rd_chk(OFS_IRQ_STS, 32'h0);
    pulse(8'h08);
    settle();
    `CHK(irq, 1);
    $display("interrupt test done");
    stop_test();
  end

  // The tests need well under a thousand cycles.
  initial begin
    #(3000 * 50);
    failures++;
    stop_test();
  end
endmodule : tb
